// ### src/dsp_kedge.sv
`timescale 1ns/10ps
`default_nettype none

// Finds rising edges of both input clocks; they arrive as plain inputs
module dsp_kedge
    import dsp_pkg::*;
(
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic k_clk,
    input  wire logic k_clk_n,
    output logic      k_rise,
    output logic      kn_rise
);

    logic k_q;
    logic kn_q;

    // Reset high so a clock already high at release is not seen as an edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            k_q <= DSP_CLK_RST;
        end else begin
            k_q <= k_clk;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            kn_q <= DSP_CLK_RST;
        end else begin
            kn_q <= k_clk_n;
        end
    end

    assign k_rise  = k_clk & ~k_q;
    assign kn_rise = k_clk_n & ~kn_q;

endmodule

`default_nettype wire

// ### src/dsp_lane_merge.sv
`timescale 1ns/10ps
`default_nettype none

// Replaces only the lanes whose select is low
module dsp_lane_merge
    import dsp_pkg::*;
(
    input  wire logic [DSP_DATA_W-1:0] old_word,
    input  wire logic [DSP_DATA_W-1:0] new_word,
    input  wire logic [DSP_LANES-1:0]  lane_sel_n,
    output logic      [DSP_DATA_W-1:0] merged
);

    for (genvar l = 0; l < DSP_LANES; l++) begin : g_lane
        localparam int unsigned LO = l * DSP_LANE_W;
        assign merged[LO +: DSP_LANE_W] =
            lane_sel_n[l] ? old_word[LO +: DSP_LANE_W]
                          : new_word[LO +: DSP_LANE_W];
    end

endmodule

`default_nettype wire

// ### src/dsp_pkg.sv
package dsp_pkg;

    localparam int unsigned DSP_DATA_W      = 36;
    localparam int unsigned DSP_ADDR_W      = 19;
    localparam int unsigned DSP_LANE_W      = 9;
    localparam int unsigned DSP_LANES       = 4;
    localparam int unsigned DSP_BEAT_W      = 2;
    localparam int unsigned DSP_WORD_IDX_W  = DSP_ADDR_W + DSP_BEAT_W;
    localparam int unsigned DSP_WORDS       = 2 ** DSP_WORD_IDX_W;

    localparam logic [DSP_BEAT_W-1:0] DSP_BEAT_FIRST = 2'h0;
    localparam logic [DSP_BEAT_W-1:0] DSP_BEAT_STEP  = 2'h1;
    localparam logic [DSP_BEAT_W-1:0] DSP_BEAT_LAST  = 2'h3;

    localparam logic [DSP_ADDR_W-1:0] DSP_ADDR_RST   = 19'h0_0000;
    localparam logic [DSP_DATA_W-1:0] DSP_DATA_RST   = 36'h0_0000_0000;
    localparam logic                  DSP_CLK_RST    = 1'b1;

    typedef enum logic {
        DSP_IDLE,
        DSP_BURST
    } dsp_port_state_t;

endpackage

// ### src/dsp_sram_io.sv
// Summary of operation
// - Write data is stored on both input clock rises only during a write.
// - A low write select sampled on a positive clock rise starts a write.
// - A deselected write port ignores the data inputs and changes no word.
// - Four active-low lane selects gate their lanes on each write beat.
// - Lanes 0 to 3 are bits 8:0, 17:9, 26:18 and 35:27.
// - A lane whose select is high keeps its stored contents.
// - The controller presents each lane select with its data word.
// - The address is sampled on the K rise that starts a read or write.
// - One address bus, time-shared by the controller, serves both ports.
// - A 19-bit address picks a burst in four arrays of 512K 36-bit words.
// - The address is ignored for a port deselected at the K rise.
// - A read launches a new 36-bit word on each rise of both input clocks.
// - A deselected read port leaves its outputs undriven.
// - A low read select sampled on a K rise starts a four-word read.
// - Outputs release at the K rise after the pending read burst ends.
`timescale 1ns/10ps
`default_nettype none

module dsp_sram_io
    import dsp_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire logic                  k_clk,
    input  wire logic                  k_clk_n,
    input  wire logic                  write_port_select_n,
    input  wire logic                  read_port_select_n,
    input  wire logic [DSP_LANES-1:0]  byte_lane_write_select_n,
    input  wire logic [DSP_ADDR_W-1:0] addr,
    input  wire logic [DSP_DATA_W-1:0] wdata,
    output logic      [DSP_DATA_W-1:0] rdata,
    output logic                       rdata_oe
);

    logic                      k_rise;
    logic                      kn_rise;
    logic                      beat_edge;

    dsp_port_state_t           wr_state_q;
    logic [DSP_BEAT_W-1:0]     wcnt_q;
    logic [DSP_ADDR_W-1:0]     wadr_q;
    logic                      wr_accept;
    logic                      mem_we;
    logic [DSP_WORD_IDX_W-1:0] widx;
    logic [DSP_DATA_W-1:0]     old_word;
    logic [DSP_DATA_W-1:0]     merged;

    dsp_port_state_t           rd_state_q;
    logic [DSP_BEAT_W-1:0]     rcnt_q;
    logic [DSP_ADDR_W-1:0]     radr_q;
    logic                      rd_accept;
    logic                      rd_beat;
    logic [DSP_WORD_IDX_W-1:0] ridx;
    logic [DSP_DATA_W-1:0]     rword;
    logic [DSP_DATA_W-1:0]     rdata_q;
    logic                      rdata_oe_q;

    // Whole store held here; not reset, contents are undefined at power-up
    logic [DSP_DATA_W-1:0]     mem_q [DSP_WORDS];

    dsp_kedge u_kedge (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .k_clk   (k_clk),
        .k_clk_n (k_clk_n),
        .k_rise  (k_rise),
        .kn_rise (kn_rise)
    );

    assign beat_edge = k_rise | kn_rise;

    // Write port. A new burst may be taken on the K rise of the last beat,
    // so back-to-back writes stream without a gap.
    assign wr_accept = k_rise && !write_port_select_n
                    && (wr_state_q == DSP_IDLE
                        || wcnt_q == DSP_BEAT_LAST);
    assign mem_we    = beat_edge && (wr_state_q == DSP_BURST);
    assign widx      = {wadr_q, wcnt_q};
    assign old_word  = mem_q[widx];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_state_q <= DSP_IDLE;
        end else begin
            case (wr_state_q)
                DSP_IDLE: begin
                    if (wr_accept) begin
                        wr_state_q <= DSP_BURST;
                    end
                end
                DSP_BURST: begin
                    if (mem_we && wcnt_q == DSP_BEAT_LAST && !wr_accept) begin
                        wr_state_q <= DSP_IDLE;
                    end
                end
                default: begin
                    wr_state_q <= DSP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wcnt_q <= DSP_BEAT_FIRST;
        end else if (wr_accept) begin
            wcnt_q <= DSP_BEAT_FIRST;
        end else if (mem_we) begin
            wcnt_q <= wcnt_q + DSP_BEAT_STEP;
        end
    end

    // Address only taken when the port is selected
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wadr_q <= DSP_ADDR_RST;
        end else if (wr_accept) begin
            wadr_q <= addr;
        end
    end

    dsp_lane_merge u_merge (
        .old_word   (old_word),
        .new_word   (wdata),
        .lane_sel_n (byte_lane_write_select_n),
        .merged     (merged)
    );

    // Lane selects and data are taken from the same edge
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem_q[widx] <= merged;
        end
    end

    // Read port. Same shape as the write port; the address bus is shared,
    // so a read and write started together would use one address.
    assign rd_accept = k_rise && !read_port_select_n
                    && (rd_state_q == DSP_IDLE
                        || rcnt_q == DSP_BEAT_LAST);
    assign rd_beat   = beat_edge && (rd_state_q == DSP_BURST);
    assign ridx      = {radr_q, rcnt_q};
    assign rword     = mem_q[ridx];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_state_q <= DSP_IDLE;
        end else begin
            case (rd_state_q)
                DSP_IDLE: begin
                    if (rd_accept) begin
                        rd_state_q <= DSP_BURST;
                    end
                end
                DSP_BURST: begin
                    if (rd_beat && rcnt_q == DSP_BEAT_LAST && !rd_accept) begin
                        rd_state_q <= DSP_IDLE;
                    end
                end
                default: begin
                    rd_state_q <= DSP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rcnt_q <= DSP_BEAT_FIRST;
        end else if (rd_accept) begin
            rcnt_q <= DSP_BEAT_FIRST;
        end else if (rd_beat) begin
            rcnt_q <= rcnt_q + DSP_BEAT_STEP;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            radr_q <= DSP_ADDR_RST;
        end else if (rd_accept) begin
            radr_q <= addr;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= DSP_DATA_RST;
        end else if (rd_beat) begin
            rdata_q <= rword;
        end
    end

    // Last word stays driven through the K-bar half, released at next K rise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_oe_q <= 1'b0;
        end else if (rd_beat) begin
            rdata_oe_q <= 1'b1;
        end else if (k_rise) begin
            rdata_oe_q <= 1'b0;
        end
    end

    assign rdata    = rdata_q;
    assign rdata_oe = rdata_oe_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_wr_start;
        k_rise && !write_port_select_n && wr_state_q == DSP_IDLE;
    endsequence

    sequence s_rd_start;
        k_rise && !read_port_select_n && rd_state_q == DSP_IDLE;
    endsequence

    sequence s_rd_burst_end;
        rd_beat && rcnt_q == DSP_BEAT_LAST && !rd_accept;
    endsequence

    property p_wr_start;
        s_wr_start |=> wr_state_q == DSP_BURST && wcnt_q == DSP_BEAT_FIRST
                       && wadr_q == $past(addr);
    endproperty
    a_wr_start: assert property (p_wr_start)
        else $error("write select not taken");

    property p_wr_idle_no_store;
        k_rise && write_port_select_n && wr_state_q == DSP_IDLE
            |=> wr_state_q == DSP_IDLE && $stable(wadr_q);
    endproperty
    a_wr_idle_no_store: assert property (p_wr_idle_no_store)
        else $error("store while write port idle");

    property p_wr_full_word;
        mem_we && byte_lane_write_select_n == 4'h0
            |=> mem_q[$past(widx)] == $past(wdata);
    endproperty
    a_wr_full_word: assert property (p_wr_full_word)
        else $error("write word not stored");

    property p_lane_keep;
        mem_we && byte_lane_write_select_n[0] && byte_lane_write_select_n[3]
            |=> mem_q[$past(widx)][8:0] == $past(old_word[8:0])
                && mem_q[$past(widx)][35:27] == $past(old_word[35:27]);
    endproperty
    a_lane_keep: assert property (p_lane_keep)
        else $error("deselected lane altered");

    property p_lane_take;
        mem_we && !byte_lane_write_select_n[1] && !byte_lane_write_select_n[2]
            |=> mem_q[$past(widx)][17:9] == $past(wdata[17:9])
                && mem_q[$past(widx)][26:18] == $past(wdata[26:18]);
    endproperty
    a_lane_take: assert property (p_lane_take)
        else $error("selected lane not stored");

    property p_wr_four_beats;
        mem_we && !wr_accept
            |=> wcnt_q == $past(wcnt_q) + DSP_BEAT_STEP
                && (wr_state_q == DSP_IDLE)
                   == ($past(wcnt_q) == DSP_BEAT_LAST);
    endproperty
    a_wr_four_beats: assert property (p_wr_four_beats)
        else $error("write burst count not cleared");

    property p_rd_start;
        s_rd_start |=> rd_state_q == DSP_BURST && rcnt_q == DSP_BEAT_FIRST
                       && radr_q == $past(addr);
    endproperty
    a_rd_start: assert property (p_rd_start)
        else $error("read select not taken");

    property p_rd_ignore;
        k_rise && read_port_select_n && rd_state_q == DSP_IDLE
            |=> rd_state_q == DSP_IDLE && $stable(radr_q);
    endproperty
    a_rd_ignore: assert property (p_rd_ignore)
        else $error("deselected read port took address");

    property p_rd_word;
        rd_beat |=> rdata_oe && rdata == $past(rword);
    endproperty
    a_rd_word: assert property (p_rd_word)
        else $error("read beat not launched");

    property p_rd_release;
        s_rd_burst_end ##1 (!k_rise) [*3] ##1 k_rise
            |=> !rdata_oe;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("outputs not released after burst");

    property p_rd_idle_quiet;
        rd_state_q == DSP_IDLE && k_rise |=> !rdata_oe;
    endproperty
    a_rd_idle_quiet: assert property (p_rd_idle_quiet)
        else $error("outputs driven while read port idle");

endmodule

`default_nettype wire

// ### tb/dsp_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none

// Controller stand-in: plays queued half-cycle slots on K and K-bar rises
module dsp_ctl_model
    import dsp_pkg::*;
(
    input  wire logic                  mclk,
    output logic                       k_clk,
    output logic                       k_clk_n,
    output logic                       write_port_select_n,
    output logic                       read_port_select_n,
    output logic      [DSP_LANES-1:0]  byte_lane_write_select_n,
    output logic      [DSP_ADDR_W-1:0] addr,
    output logic      [DSP_DATA_W-1:0] wdata
);
    // Slot: write select, read select, lane selects, address, data
    logic [60:0] slots [$];
    logic [60:0] cur_q  = {6'h3f, 55'h00_0000_0000_0000};
    logic [1:0]  ph_q   = 2'h3;
    logic        busy_q = 1'b0;

    // Free-running pair, four mclk cycles a period
    assign k_clk   = ~ph_q[1];
    assign k_clk_n = ph_q[1];
    assign write_port_select_n = cur_q[60];
    assign read_port_select_n  = cur_q[59];
    assign byte_lane_write_select_n = cur_q[58:55];
    assign addr = cur_q[54:36];
    assign wdata = cur_q[35:0];

    always @(posedge mclk) begin
        #1;
        ph_q = ph_q + 2'h1;
        if (!ph_q[0]) begin
            // A burst may only start on a K rise
            if (slots.size() > 0 && (busy_q || ph_q == 2'h0)) begin
                cur_q  = slots.pop_front();
                busy_q = 1'b1;
            end else begin
                // Idle lines toggle so stale values never look valid
                cur_q  = {6'h3f, ~cur_q[54:0]};
                busy_q = 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import dsp_pkg::*;

    logic                  mclk   = 1'b0;
    logic                  arst_n = 1'b0;
    wire logic             k_clk;
    wire logic             k_clk_n;
    wire logic             write_port_select_n;
    wire logic             read_port_select_n;
    wire logic [3:0]       byte_lane_write_select_n;
    wire logic [18:0]      addr;
    wire logic [35:0]      wdata;
    wire logic [35:0]      rdata;
    wire logic             rdata_oe;
    logic      [60:0]      tl [0:31];
    logic      [35:0]      mem [logic [20:0]];
    logic      [35:0]      exp_q [$];
    logic      [31:0]      lf = 32'h0000_0056;
    int                    miscompares = 0;
    int                    samples_checked = 0;
    logic                  pk_q = 1'b1;
    logic                  pkn_q = 1'b1;
    logic      [1:0]       due_q = 2'h0;
    logic      [1:0]       rel_q = 2'h0;
    logic                  now;
    int                    beats = 0;

    always #12.5 mclk = ~mclk;

    dsp_ctl_model ctl (.mclk(mclk), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .write_port_select_n(write_port_select_n),
        .read_port_select_n(read_port_select_n),
        .byte_lane_write_select_n(byte_lane_write_select_n),
        .addr(addr), .wdata(wdata));

    dsp_sram_io dut (.mclk(mclk), .arst_n(arst_n), .k_clk(k_clk),
        .k_clk_n(k_clk_n), .write_port_select_n(write_port_select_n),
        .read_port_select_n(read_port_select_n),
        .byte_lane_write_select_n(byte_lane_write_select_n),
        .addr(addr), .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe));

    function automatic logic [35:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return {lf[3:0], lf};
    endfunction

    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string w, input logic [35:0] e,
                       input logic [35:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask

    // Idle slots carry live random address and data
    task automatic clr();
        logic [35:0] r;
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            tl[i] = {6'h3f, r[18:0], rnd()};
        end
    endtask

    // Lanes: four select nibbles, first beat in the low nibble
    task automatic wr_at(input int i, input logic [18:0] a,
                         input logic [15:0] lanes);
        logic [35:0] w;
        logic [35:0] m;
        tl[i][60] = 1'b0;
        tl[i][54:36] = a;
        for (int b = 0; b < 4; b++) begin
            w = rnd();
            m = mem.exists({a, b[1:0]}) ? mem[{a, b[1:0]}] : 'x;
            for (int l = 0; l < 4; l++)
                if (!lanes[4*b+l]) m[9*l +: 9] = w[9*l +: 9];
            mem[{a, b[1:0]}] = m;
            tl[i+1+b][58:55] = lanes[4*b +: 4];
            tl[i+1+b][35:0] = w;
        end
    endtask

    task automatic rd_at(input int i, input logic [18:0] a);
        tl[i][59] = 1'b0;
        tl[i][54:36] = a;
        for (int b = 0; b < 4; b++)
            exp_q.push_back(mem[{a, b[1:0]}]);
    endtask

    task automatic play(input int n);
        for (int i = 0; i < n; i++)
            ctl.slots.push_back(tl[i]);
        for (int t = 0; t < 400; t++)
            if (ctl.slots.size() > 0 || exp_q.size() > 0)
                @(posedge mclk);
        repeat (12) @(posedge mclk);
        clr();
    endtask

    // Words are checked two edges after their beat, whichever edge loads
    always @(posedge mclk) begin
        if (due_q[1]) begin
            chk("rdata_oe", 36'h1, {35'h0, rdata_oe});
            if (exp_q.size() > 0)
                chk("rdata", exp_q.pop_front(), rdata);
        end
        if (rel_q[1])
            chk("rdata_oe", 36'h0, {35'h0, rdata_oe});
        if (!arst_n) begin
            pk_q = 1'b1;
            pkn_q = 1'b1;
            beats = 0;
            due_q = 2'h0;
            rel_q = 2'h0;
        end else begin
            now = beats > 0 && ((k_clk && !pk_q) || (k_clk_n && !pkn_q));
            if (now)
                beats--;
            due_q = {due_q[0], now};
            rel_q = {rel_q[0], k_clk && !pk_q && !now && beats == 0 &&
                     read_port_select_n};
            if (k_clk && !pk_q && beats == 0 && !read_port_select_n)
                beats = 4;
            pk_q = k_clk;
            pkn_q = k_clk_n;
        end
    end

    initial begin
        repeat (6000) @(posedge mclk);
        miscompares++;
        conclude();
    end

    initial begin
        logic [35:0] r;
        clr();
        repeat (20) @(posedge mclk);
        #1 arst_n = 1'b1;
        // Keep the first K rise clear of the edge detector's reset value
        repeat (2) @(posedge mclk);
        wr_at(0, 19'h0_0000, 16'h0000);
        wr_at(4, 19'h7_ffff, 16'h0000);
        rd_at(10, 19'h0_0000);
        rd_at(14, 19'h7_ffff);
        play(22);
        wr_at(0, 19'h7_ffff, 16'h7bde);
        wr_at(4, 19'h0_0000, 16'hffff);
        // Deselected write with live address, data and lanes
        tl[10][54:36] = 19'h0_0000;
        for (int i = 11; i < 15; i++)
            tl[i][58:55] = 4'h0;
        rd_at(16, 19'h7_ffff);
        rd_at(20, 19'h0_0000);
        play(28);
        for (int n = 0; n < 6; n++) begin
            r = rnd();
            wr_at(0, {1'b0, r[17:0]}, 16'h0000);
            rd_at(2, 19'h7_ffff);
            wr_at(4, {1'b0, r[17:0]}, r[35:20]);
            rd_at(10, {1'b0, r[17:0]});
            play(18);
        end
        if (exp_q.size() != 0) begin
            miscompares++;
            $display("mismatch pending_words expected 0 seen %0d",
                     exp_q.size());
        end
        conclude();
    end
endmodule

`default_nettype wire
